/* File: uic_params.svh */
// uic_params.svh: constants of the interface control register block
// assumes: included by bare name from the package and design files
`ifndef UIC_PARAMS_SVH
`define UIC_PARAMS_SVH

// =====================================
// register map
`define UIC_ADDR_CTRL 6'h07
`define UIC_ADDR_SET 6'h08
`define UIC_ADDR_CLR 6'h09
`define UIC_CTRL_RESET 8'h10
`define UIC_READ_UNMAPPED 8'h00

// =====================================
// bits cleared by the device itself
`define UIC_BIT_UART 2
`define UIC_BIT_SER3 1
`define UIC_BIT_SER6 0

// =====================================
// transmit command codes, data bits 7:6
`define UIC_CMD_WRITE 2'h2
`define UIC_CMD_READ 2'h3

// =====================================
// width of the synchronised pin vector
`define UIC_SYNC_W 12

`endif

/* File: uic_pkg.sv */
// uic_pkg: types of the interface control register block
// assumes: uic_params.svh on the include path
`include "uic_params.svh"

package uic_pkg;

  // =====================================
  // register layout, bit 7 first
  typedef struct packed {
    logic guard_circuit_off;
    logic indicator_unqualified;
    logic indicator_invert;
    logic auto_wake_signal;
    logic serial_clock_keep_on_n;
    logic uart_mode_select;
    logic three_wire_serial_select;
    logic six_wire_serial_select;
  } uic_ctrl_t;

  // register access taken from the link
  typedef struct packed {
    logic wr;
    logic [5:0] addr;
    logic [7:0] data;
  } uic_reg_req_t;

  typedef enum logic [1:0] {
    UIC_TGT_NONE = 2'h0,
    UIC_TGT_CTRL = 2'h1,
    UIC_TGT_SET = 2'h2,
    UIC_TGT_CLR = 2'h3
  } uic_target_t;

  // link protocol states, gray on each step away from idle
  typedef enum logic [2:0] {
    UIC_ST_IDLE = 3'h0,
    UIC_ST_WR_CMD = 3'h1,
    UIC_ST_WR_DATA = 3'h3,
    UIC_ST_RD_CMD = 3'h4,
    UIC_ST_RD_TURN = 3'h5,
    UIC_ST_RD_DATA = 3'h7
  } uic_state_t;

  function automatic uic_target_t uic_decode(input logic [5:0] addr);
    uic_target_t t;
    t = UIC_TGT_NONE;
    if (addr == `UIC_ADDR_CTRL) t = UIC_TGT_CTRL;
    if (addr == `UIC_ADDR_SET) t = UIC_TGT_SET;
    if (addr == `UIC_ADDR_CLR) t = UIC_TGT_CLR;
    return t;
  endfunction : uic_decode

endpackage : uic_pkg

/* File: uic_pin_sync.sv */
// uic_pin_sync: two-stage synchroniser for pins from outside the clock
// assumes: inputs are levels held at least two clock periods
`timescale 1ns/1ps
`default_nettype none

module uic_pin_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // pins
  input wire logic [W-1:0] async_in,
  output var logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : uic_pin_sync

`default_nettype wire

/* File: uic_reg_core.sv */
// uic_reg_core: interface control register with set and clear aliases
// assumes: one write request per cycle, mode-exit pulses on this clock
`timescale 1ns/1ps
`default_nettype none
`include "uic_params.svh"

module uic_reg_core (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // access from the link
  input wire uic_pkg::uic_reg_req_t req,
  output logic [7:0] rd_data,
  // device mode exits
  input wire logic uart_mode_exit,
  input wire logic serial_mode_exit,
  // register value
  output uic_pkg::uic_ctrl_t ctrl_q
);

  uic_pkg::uic_target_t tgt;
  uic_pkg::uic_ctrl_t ctrl_d;
  logic [7:0] hw_clr;
  logic [7:0] base;

  assign tgt = uic_pkg::uic_decode(req.addr);
  assign rd_data = (tgt == uic_pkg::UIC_TGT_NONE) ? `UIC_READ_UNMAPPED : ctrl_q;

  // =====================================
  // next value
  always_comb begin
    hw_clr = 8'h00;
    hw_clr[`UIC_BIT_UART] = uart_mode_exit;
    hw_clr[`UIC_BIT_SER3] = serial_mode_exit;
    hw_clr[`UIC_BIT_SER6] = serial_mode_exit;
    base = ctrl_q & ~hw_clr;
    ctrl_d = uic_pkg::uic_ctrl_t'(base);
    if (req.wr) begin
      unique case (tgt)
        uic_pkg::UIC_TGT_CTRL: ctrl_d = uic_pkg::uic_ctrl_t'(req.data);
        uic_pkg::UIC_TGT_SET: ctrl_d = uic_pkg::uic_ctrl_t'(base | req.data);
        uic_pkg::UIC_TGT_CLR: ctrl_d = uic_pkg::uic_ctrl_t'(base & ~req.data);
        uic_pkg::UIC_TGT_NONE: ctrl_d = uic_pkg::uic_ctrl_t'(base);
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl_q <= uic_pkg::uic_ctrl_t'(`UIC_CTRL_RESET);
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // =====================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  chk_reset_value: assert property ($past(!rst_n) |-> ctrl_q == `UIC_CTRL_RESET)
    else $error("control register not at reset value");
  chk_write_full: assert property (
    req.wr && tgt == uic_pkg::UIC_TGT_CTRL |=> ctrl_q == $past(req.data))
    else $error("full write not stored");
  chk_set_alias: assert property (
    req.wr && tgt == uic_pkg::UIC_TGT_SET && !uart_mode_exit && !serial_mode_exit
    |=> ctrl_q == ($past(ctrl_q) | $past(req.data)))
    else $error("set alias wrong");
  chk_clear_alias: assert property (
    req.wr && tgt == uic_pkg::UIC_TGT_CLR |=> (ctrl_q & $past(req.data)) == 8'h00)
    else $error("clear alias left a bit set");
  chk_uart_autoclr: assert property (
    uart_mode_exit && !req.wr |=> !ctrl_q.uart_mode_select)
    else $error("uart select not cleared on exit");
  chk_serial_autoclr: assert property (
    serial_mode_exit && !req.wr
    |=> !ctrl_q.three_wire_serial_select && !ctrl_q.six_wire_serial_select)
    else $error("serial select not cleared on exit");

endmodule : uic_reg_core

`default_nettype wire

/* File: uic_ulpi_ctrl.sv */
// uic_ulpi_ctrl: interface control register reached over ULPI register access
// assumes: link clock much slower than clock; link drives pins after its rising edge
// What this block does
// - The interface control register is an 8-bit read-write register at address 0x07.
// - Bit 7 resets to 0 and, when set, switches off the interface guard circuitry.
// - Bit 5 resets to 0 and, when set, inverts the external bus-power flag.
// - Bit 6 resets to 0; when clear the flag is ANDed with the internal valid comparator.
// - Bit 4 resets to 1 and enables automatic resume signalling while set.
// - Bit 3 resets to 0 and keeps the clock powered in serial and UART modes when set.
// - Bit 3 is ignored while low_power_n is 0.
// - Bit 2 resets to 0 and, when set, turns the pins into a UART interface.
// - The device clears bit 2 itself when UART mode is exited.
// - Bit 1 resets to 0 and, when set, selects the 3-pin serial interface.
// - Bit 0 resets to 0 and, when set, selects the 6-pin serial interface.
// - The device clears the serial select bits itself when serial mode is exited.
// - Address 0x08 sets the bits written as 1 and reads back the register.
// - Address 0x09 clears the bits written as 1 and reads back the register.
`timescale 1ns/1ps
`default_nettype none
`include "uic_params.svh"

module uic_ulpi_ctrl (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // link pins
  input wire logic ulpi_clk_in,
  input wire logic ulpi_stp,
  input wire logic [7:0] ulpi_data_i,
  output logic [7:0] ulpi_data_o,
  output logic ulpi_data_oe,
  output logic ulpi_dir,
  output logic ulpi_nxt,
  // bus power sensing
  input wire logic ext_bus_power_flag_in,
  input wire logic bus_power_valid_in,
  output logic rxcmd_bus_power,
  // device mode logic
  input wire logic low_power_n,
  input wire logic uart_mode_exit,
  input wire logic serial_mode_exit,
  // controls to the transceiver
  output logic guard_active,
  output logic auto_wake_enable,
  output logic uart_mode,
  output logic three_wire_mode,
  output logic six_wire_mode,
  output logic serial_clock_powered
);

  logic [`UIC_SYNC_W-1:0] sync_s;
  logic clk_s;
  logic stp_s;
  logic [7:0] data_s;
  logic flag_s;
  logic valid_s;
  logic clk_prev_q;
  logic link_fall;
  logic [1:0] cmd;
  uic_pkg::uic_state_t state_q;
  logic [5:0] addr_q;
  logic [7:0] wdata_q;
  logic [7:0] rd_data;
  logic [7:0] data_o_q;
  logic bus_power_q;
  logic clk_power_q;
  logic comp;
  uic_pkg::uic_reg_req_t req;
  uic_pkg::uic_ctrl_t ctrl_q;
  logic [1:0] frame_falls_q;

  // =====================================
  // pin synchronisers and link clock edge
  uic_pin_sync #(
    .W(`UIC_SYNC_W)
  ) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .async_in({bus_power_valid_in, ext_bus_power_flag_in, ulpi_stp, ulpi_data_i,
               ulpi_clk_in}),
    .sync_out(sync_s)
  );

  assign clk_s = sync_s[0];
  assign data_s = sync_s[8:1];
  assign stp_s = sync_s[9];
  assign flag_s = sync_s[10];
  assign valid_s = sync_s[11];
  assign cmd = data_s[7:6];

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      clk_prev_q <= 1'b0;
    end else begin
      clk_prev_q <= clk_s;
    end
  end

  // pins are sampled mid-period, on the falling link edge
  assign link_fall = clk_prev_q && !clk_s;

  // =====================================
  // register access protocol
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_q <= uic_pkg::UIC_ST_IDLE;
      addr_q <= 6'h00;
      wdata_q <= 8'h00;
    end else if (link_fall) begin
      unique case (state_q)
        uic_pkg::UIC_ST_IDLE: begin
          addr_q <= data_s[5:0];
          if (cmd == `UIC_CMD_WRITE) begin
            state_q <= uic_pkg::UIC_ST_WR_CMD;
          end else if (cmd == `UIC_CMD_READ) begin
            state_q <= uic_pkg::UIC_ST_RD_CMD;
          end
        end
        uic_pkg::UIC_ST_WR_CMD: begin
          wdata_q <= data_s;
          state_q <= stp_s ? uic_pkg::UIC_ST_IDLE : uic_pkg::UIC_ST_WR_DATA;
        end
        uic_pkg::UIC_ST_WR_DATA: begin
          if (stp_s) begin
            state_q <= uic_pkg::UIC_ST_IDLE;
          end
        end
        uic_pkg::UIC_ST_RD_CMD: state_q <= uic_pkg::UIC_ST_RD_TURN;
        uic_pkg::UIC_ST_RD_TURN: state_q <= uic_pkg::UIC_ST_RD_DATA;
        uic_pkg::UIC_ST_RD_DATA: state_q <= uic_pkg::UIC_ST_IDLE;
        default: state_q <= uic_pkg::UIC_ST_IDLE;
      endcase
    end
  end

  // write commits when the link stops after the data byte
  always_comb begin
    req.wr = link_fall && stp_s && state_q == uic_pkg::UIC_ST_WR_DATA;
    req.addr = addr_q;
    req.data = wdata_q;
  end

  // read data loaded as the bus turns round to the device
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      data_o_q <= 8'h00;
    end else if (link_fall && state_q == uic_pkg::UIC_ST_RD_TURN) begin
      data_o_q <= rd_data;
    end
  end

  assign ulpi_data_o = data_o_q;
  assign ulpi_nxt = state_q == uic_pkg::UIC_ST_WR_CMD || state_q == uic_pkg::UIC_ST_WR_DATA
                    || state_q == uic_pkg::UIC_ST_RD_CMD;
  assign ulpi_dir = state_q == uic_pkg::UIC_ST_RD_TURN || state_q == uic_pkg::UIC_ST_RD_DATA;
  assign ulpi_data_oe = state_q == uic_pkg::UIC_ST_RD_DATA;

  // =====================================
  // register bank
  uic_reg_core u_core (
    .clock(clock),
    .rst_n(rst_n),
    .req(req),
    .rd_data(rd_data),
    .uart_mode_exit(uart_mode_exit),
    .serial_mode_exit(serial_mode_exit),
    .ctrl_q(ctrl_q)
  );

  // =====================================
  // bus power state for the receive command
  assign comp = flag_s ^ ctrl_q.indicator_invert;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      bus_power_q <= 1'b0;
    end else if (ctrl_q.indicator_unqualified) begin
      bus_power_q <= comp;
    end else begin
      bus_power_q <= comp && valid_s;
    end
  end

  assign rxcmd_bus_power = bus_power_q;

  // =====================================
  // clock power in serial and uart modes
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      clk_power_q <= 1'b0;
    end else begin
      clk_power_q <= low_power_n && ctrl_q.serial_clock_keep_on_n
                     && (ctrl_q.uart_mode_select || ctrl_q.three_wire_serial_select
                         || ctrl_q.six_wire_serial_select);
    end
  end

  assign serial_clock_powered = clk_power_q;

  // =====================================
  // mode and feature controls
  assign guard_active = !ctrl_q.guard_circuit_off;
  assign auto_wake_enable = ctrl_q.auto_wake_signal;
  assign uart_mode = ctrl_q.uart_mode_select;
  assign three_wire_mode = ctrl_q.three_wire_serial_select;
  assign six_wire_mode = ctrl_q.six_wire_serial_select;

  // =====================================
  // checks

  // link falls since the command, read by the frame checks
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      frame_falls_q <= 2'h0;
    end else if (link_fall) begin
      if (state_q == uic_pkg::UIC_ST_IDLE) begin
        frame_falls_q <= 2'h0;
      end else if (frame_falls_q != 2'h3) begin
        frame_falls_q <= frame_falls_q + 2'h1;
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_wr_cmd;
    link_fall && state_q == uic_pkg::UIC_ST_IDLE && cmd == `UIC_CMD_WRITE;
  endsequence

  sequence s_rd_cmd;
    link_fall && state_q == uic_pkg::UIC_ST_IDLE && cmd == `UIC_CMD_READ;
  endsequence

  sequence s_rd_turn_fall;
    link_fall && state_q == uic_pkg::UIC_ST_RD_TURN;
  endsequence

  sequence s_rd_data_fall;
    link_fall && state_q == uic_pkg::UIC_ST_RD_DATA;
  endsequence

  sequence s_wr_stop;
    link_fall && state_q == uic_pkg::UIC_ST_WR_DATA && stp_s;
  endsequence

  sequence s_turn_seen;
    ulpi_dir && !ulpi_nxt && !ulpi_data_oe;
  endsequence

  chk_write_nxt: assert property (s_wr_cmd |=> ulpi_nxt && !ulpi_dir)
    else $error("write command not acknowledged");
  chk_read_turn: assert property (
    s_rd_cmd |=> (ulpi_nxt && !ulpi_dir)[*8] ##[1:32] s_turn_seen)
    else $error("read turnaround wrong");
  chk_read_value: assert property (
    link_fall && state_q == uic_pkg::UIC_ST_RD_TURN
    && uic_pkg::uic_decode(addr_q) != uic_pkg::UIC_TGT_NONE
    |=> ulpi_data_o == $past(ctrl_q))
    else $error("read did not return register value");
  chk_clk_gate: assert property (!low_power_n |=> !serial_clock_powered)
    else $error("clock powered while in low power");
  chk_invert_path: assert property (
    ctrl_q.indicator_unqualified |=> rxcmd_bus_power == $past(flag_s ^ ctrl_q.indicator_invert))
    else $error("bus power flag polarity wrong");
  chk_qualify: assert property (!ctrl_q.indicator_unqualified && !valid_s |=> !rxcmd_bus_power)
    else $error("bus power not qualified");

  // read and write frame checks
  chk_read_drive: assert property (
    s_rd_turn_fall |=> ulpi_dir && ulpi_data_oe && !ulpi_nxt)
    else $error("read data phase wrong");
  chk_read_release: assert property (
    s_rd_data_fall |=> !ulpi_dir && !ulpi_data_oe && !ulpi_nxt)
    else $error("bus not handed back after read");
  chk_read_length: assert property (s_rd_data_fall |-> frame_falls_q == 2'h2)
    else $error("read frame length wrong");
  chk_write_stop: assert property (
    s_wr_stop |=> !ulpi_nxt && state_q == uic_pkg::UIC_ST_IDLE)
    else $error("write not ended by stop");
  chk_write_after_data: assert property (req.wr |-> frame_falls_q != 2'h0)
    else $error("write committed before its data byte");
  chk_write_abort: assert property (
    link_fall && state_q == uic_pkg::UIC_ST_WR_CMD && stp_s
    |=> state_q == uic_pkg::UIC_ST_IDLE)
    else $error("stopped write command not dropped");
  chk_unmapped_read: assert property (
    link_fall && state_q == uic_pkg::UIC_ST_RD_TURN
    && uic_pkg::uic_decode(addr_q) == uic_pkg::UIC_TGT_NONE |=> ulpi_data_o == `UIC_READ_UNMAPPED)
    else $error("unmapped read not zero");
  chk_other_cmd: assert property (
    link_fall && state_q == uic_pkg::UIC_ST_IDLE && !data_s[7]
    |=> state_q == uic_pkg::UIC_ST_IDLE)
    else $error("unknown command not ignored");

  // clock power checks
  chk_clk_keep: assert property (
    low_power_n && ctrl_q.serial_clock_keep_on_n
    && (ctrl_q.uart_mode_select || ctrl_q.three_wire_serial_select
        || ctrl_q.six_wire_serial_select) |=> serial_clock_powered)
    else $error("clock not kept powered in serial mode");
  chk_clk_off: assert property (
    !ctrl_q.serial_clock_keep_on_n |=> !serial_clock_powered)
    else $error("clock powered while keep-on bit clear");

endmodule : uic_ulpi_ctrl

`default_nettype wire

/* File: uic_link_model.sv */
// uic_link_model: link controller issuing ULPI register writes and reads
// assumes: link clock stands low between frames; pins change just after a link rise
`timescale 1ns/1ps
`default_nettype none

module uic_link_model (
  // link pins
  output logic ulpi_clk_in,
  output logic ulpi_stp,
  output logic [7:0] ulpi_data_i,
  // device answer
  input wire logic [7:0] ulpi_data_o,
  input wire logic ulpi_data_oe,
  input wire logic ulpi_dir,
  input wire logic ulpi_nxt
);
  initial begin
    ulpi_clk_in = 1'b0;
    ulpi_stp = 1'b0;
    ulpi_data_i = 8'h00;
  end

  // =====================================
  // one link period, answer to the previous fall taken at the rise
  task automatic period(input logic stp, input logic [7:0] d, output logic [2:0] s,
                        output logic [7:0] q);
    ulpi_clk_in = 1'b1;
    s = {ulpi_nxt, ulpi_dir, ulpi_data_oe};
    q = ulpi_data_o;
    #1;
    ulpi_stp = stp;
    ulpi_data_i = d;
    #61.5;
    ulpi_clk_in = 1'b0;
    #62.5;
  endtask : period

  // =====================================
  // write: command, data, stop, then one idle period
  task automatic wr(input logic [5:0] a, input logic [7:0] d, output logic [2:0] hs);
    logic [2:0] s;
    logic [7:0] q;
    period(1'b0, {2'h2, a}, s, q);
    period(1'b0, d, s, q);
    hs[2] = (s[2] === 1'b1);
    period(1'b1, 8'h00, s, q);
    hs[1] = (s[2] === 1'b1);
    period(1'b0, 8'h00, s, q);
    hs[0] = (s[2] === 1'b0);
  endtask : wr

  // =====================================
  // read: link lets go of data while dir may be high, shows inverted last byte
  task automatic rd(input logic [5:0] a, output logic [7:0] q, output logic [3:0] hs);
    logic [2:0] s;
    logic [7:0] x;
    period(1'b0, {2'h3, a}, s, x);
    period(1'b0, ~{2'h3, a}, s, x);
    hs[3] = (s === 3'h4);
    period(1'b0, ~{2'h3, a}, s, x);
    hs[2] = (s === 3'h2);
    period(1'b0, ~{2'h3, a}, s, q);
    hs[1] = (s === 3'h3);
    period(1'b0, 8'h00, s, x);
    hs[0] = (s === 3'h0);
  endtask : rd

  // =====================================
  // write cut short: stop raised with the data byte, nothing stored
  task automatic cut(input logic [5:0] a, input logic [7:0] d);
    logic [2:0] s;
    logic [7:0] q;
    period(1'b0, {2'h2, a}, s, q);
    period(1'b1, d, s, q);
    period(1'b0, 8'h00, s, q);
  endtask : cut
endmodule : uic_link_model
`default_nettype wire

/* File: ulpi_interface_control_reg_tb_top.sv */
// ulpi_interface_control_reg_tb_top: self-checking bench of the interface control register
// assumes: uic_ulpi_ctrl and uic_link_model compiled before this file
`timescale 1ns/1ps
`default_nettype none

module ulpi_interface_control_reg_tb_top;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic low_power_n = 1'b1;
  logic ext_bus_power_flag_in = 1'b0;
  logic bus_power_valid_in = 1'b0;
  logic uart_mode_exit = 1'b0;
  logic serial_mode_exit = 1'b0;
  wire logic ulpi_clk_in, ulpi_stp, ulpi_data_oe, ulpi_dir, ulpi_nxt, rxcmd_bus_power;
  wire logic guard_active, auto_wake_enable, uart_mode, three_wire_mode, six_wire_mode;
  wire logic serial_clock_powered;
  wire logic [7:0] ulpi_data_i, ulpi_data_o;
  logic [7:0] m;
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;
  integer seed = 67;
  logic [31:0] r;

  always #5 clock = ~clock;

  uic_ulpi_ctrl uut (.clock(clock), .rst_n(rst_n), .ulpi_clk_in(ulpi_clk_in),
    .ulpi_stp(ulpi_stp), .ulpi_data_i(ulpi_data_i), .ulpi_data_o(ulpi_data_o),
    .ulpi_data_oe(ulpi_data_oe), .ulpi_dir(ulpi_dir), .ulpi_nxt(ulpi_nxt),
    .ext_bus_power_flag_in(ext_bus_power_flag_in), .bus_power_valid_in(bus_power_valid_in),
    .rxcmd_bus_power(rxcmd_bus_power), .low_power_n(low_power_n),
    .uart_mode_exit(uart_mode_exit), .serial_mode_exit(serial_mode_exit),
    .guard_active(guard_active), .auto_wake_enable(auto_wake_enable), .uart_mode(uart_mode),
    .three_wire_mode(three_wire_mode), .six_wire_mode(six_wire_mode),
    .serial_clock_powered(serial_clock_powered));

  uic_link_model lnk (.ulpi_clk_in(ulpi_clk_in), .ulpi_stp(ulpi_stp),
    .ulpi_data_i(ulpi_data_i), .ulpi_data_o(ulpi_data_o), .ulpi_data_oe(ulpi_data_oe),
    .ulpi_dir(ulpi_dir), .ulpi_nxt(ulpi_nxt));

  // =====================================
  // comparison and verdict
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic results();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results

  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      results();
    end
  end

  // =====================================
  // link accesses against the reference value m
  task automatic do_wr(input logic [5:0] a, input logic [7:0] d);
    logic [2:0] hs;
    lnk.wr(a, d, hs);
    chk("write handshake", {5'h00, hs}, 8'h07);
    if (a == 6'h07) m = d;
    if (a == 6'h08) m = m | d;
    if (a == 6'h09) m = m & ~d;
  endtask : do_wr

  task automatic do_rd(input logic [5:0] a);
    logic [3:0] hs;
    logic [7:0] q;
    lnk.rd(a, q, hs);
    chk("read handshake", {4'h0, hs}, 8'h0f);
    chk("read data", q, (a >= 6'h07 && a <= 6'h09) ? m : 8'h00);
  endtask : do_rd

  task automatic outs();
    repeat (5) @(posedge clock);
    #1;
    chk("mode outputs", {3'h0, guard_active, auto_wake_enable, uart_mode, three_wire_mode,
        six_wire_mode}, {3'h0, ~m[7], m[4], m[2], m[1], m[0]});
    chk("clock power", {7'h00, serial_clock_powered},
        {7'h00, low_power_n & m[3] & (|m[2:0])});
    chk("bus power", {7'h00, rxcmd_bus_power},
        {7'h00, (ext_bus_power_flag_in ^ m[5]) & (m[6] | bus_power_valid_in)});
  endtask : outs

  task automatic do_reset();
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    m = 8'h10;
    repeat (10) @(posedge clock);
  endtask : do_reset

  task automatic pulse(input logic uart);
    @(posedge clock);
    if (uart) uart_mode_exit <= 1'b1;
    else serial_mode_exit <= 1'b1;
    @(posedge clock);
    uart_mode_exit <= 1'b0;
    serial_mode_exit <= 1'b0;
  endtask : pulse

  // =====================================
  // main sequence
  initial begin
    do_reset();
    outs();
    do_rd(6'h07);
    for (int i = 0; i < 15; i++) begin
      r = $random(seed);
      do_wr(6'h07 + 6'(i % 3), r[7:0]);
      @(posedge clock);
      low_power_n <= r[8];
      ext_bus_power_flag_in <= r[9];
      bus_power_valid_in <= r[10];
      do_rd(6'h07 + 6'(r[12:11] % 3));
      outs();
    end
    do_wr(6'h0a, 8'hff);
    do_rd(6'h0a);
    lnk.cut(6'h07, ~m);
    do_rd(6'h07);
    do_wr(6'h08, 8'h0f);
    pulse(1'b1);
    m[2] = 1'b0;
    outs();
    do_rd(6'h07);
    pulse(1'b0);
    m[1:0] = 2'h0;
    outs();
    do_rd(6'h07);
    do_reset();
    do_rd(6'h09);
    outs();
    results();
  end
endmodule : ulpi_interface_control_reg_tb_top
`default_nettype wire
